/* File: hw/adc_calibration_mode_sequencer.sv */
// Calibration mode sequencer: background, zero-scale and full-scale self-cal
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Mode 101 starts background cal on channel
// - Background interleaves zero-scale cal, sixfold slower
// - Background cal uses gain, updates coefficients
// - Mode 110 runs one zero-scale self-cal
// - Zero-scale done returns mode to 000
// - Zero-scale: ready high at start, low on next data word
// - Mode 111 runs one full-scale self-cal
// - Full-scale done returns mode to 000
// - Full-scale: ready high at start, low on next data word
module adc_calibration_mode_sequencer #(
	parameter int BG_SLOTS = cal_seq_pkg::BG_SLOTS
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic mode_wr,
	input wire logic op_mode_bit2,
	input wire logic op_mode_bit1,
	input wire logic op_mode_bit0,
	input wire logic chan_sel_bit2,
	input wire logic chan_sel_bit1,
	input wire logic chan_sel_bit0,
	input wire logic [2:0] gain_sel,
	input wire logic step_done,
	output logic step_start,
	output logic [1:0] step_kind,
	output logic [2:0] step_chan,
	output logic [2:0] step_gain,
	output logic coef_load,
	output logic data_load,
	output logic [2:0] mode,
	output logic conv_valid_n
);
	// One-hot step state
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ZS = 4'h2,
		ST_FS = 4'h4,
		ST_CONV = 4'h8
	} state_t;
	state_t state;
	logic busy;
	logic cal_slot;
	logic next_is_cal;
	logic [2:0] wr_mode;
	logic [2:0] chan;
	// Elaboration check: background mode needs a conversion slot
	if (BG_SLOTS < 2) begin : g_bad_slots
		$error("BG_SLOTS must be at least 2");
	end
	// Mode field as written, and step-in-flight flag
	assign wr_mode = {op_mode_bit2, op_mode_bit1, op_mode_bit0};
	assign busy = (state != ST_IDLE);
	// Background slots choose a zero-scale step every BG_SLOTS steps
	cal_slot_counter #(.SLOTS(BG_SLOTS)) u_slots (
		.mclk(mclk),
		.rst_n(rst_n),
		.clear(mode_wr),
		.advance(step_start && mode == cal_seq_pkg::MODE_BG_CAL),
		.cal_slot(cal_slot)
	);
	assign next_is_cal = cal_slot;
	// Mode and channel fields; self-clear after one-step cals
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			mode <= cal_seq_pkg::MODE_RESET;
			chan <= cal_seq_pkg::CHAN_RESET;
		end else if (mode_wr) begin
			mode <= wr_mode;
			chan <= {chan_sel_bit2, chan_sel_bit1, chan_sel_bit0};
		end else if (step_done && (state == ST_ZS || state == ST_FS)
				&& mode != cal_seq_pkg::MODE_BG_CAL) begin
			mode <= cal_seq_pkg::MODE_NORMAL;
		end
	end
	// Step sequencer: issues analog steps to the converter core
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			step_start <= 1'b0;
			step_kind <= cal_seq_pkg::STEP_CONV;
			step_chan <= cal_seq_pkg::CHAN_RESET;
			step_gain <= 3'h0;
		end else begin
			step_start <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (!mode_wr && mode == cal_seq_pkg::MODE_ZS_SELF) begin
						state <= ST_ZS;
						step_kind <= cal_seq_pkg::STEP_ZS;
						step_start <= 1'b1;
					end else if (!mode_wr && mode == cal_seq_pkg::MODE_FS_SELF) begin
						state <= ST_FS;
						step_kind <= cal_seq_pkg::STEP_FS;
						step_start <= 1'b1;
					end else if (!mode_wr && mode == cal_seq_pkg::MODE_BG_CAL) begin
						// Background never runs full-scale; host calibrates first
						state <= next_is_cal ? ST_ZS : ST_CONV;
						step_kind <= next_is_cal ? cal_seq_pkg::STEP_ZS
							: cal_seq_pkg::STEP_CONV;
						step_start <= 1'b1;
					end else if (!mode_wr) begin
						state <= ST_CONV;
						step_kind <= cal_seq_pkg::STEP_CONV;
						step_start <= 1'b1;
					end
					step_chan <= chan;
					step_gain <= gain_sel;
				end
				ST_ZS, ST_FS, ST_CONV: begin
					if (mode_wr || step_done) begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
	// Coefficient refresh and data word load at step end
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			coef_load <= 1'b0;
			data_load <= 1'b0;
		end else begin
			coef_load <= step_done && !mode_wr && (state == ST_ZS || state == ST_FS);
			data_load <= step_done && !mode_wr && state == ST_CONV;
		end
	end
	// Data-ready: high while one-step cal runs, low on fresh word
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			conv_valid_n <= 1'b1;
		end else if (mode_wr && (wr_mode == cal_seq_pkg::MODE_ZS_SELF
				|| wr_mode == cal_seq_pkg::MODE_FS_SELF)) begin
			conv_valid_n <= 1'b1;
		end else if (data_load) begin
			conv_valid_n <= 1'b0;
		end
	end
	// Zero-scale self-cal clears mode within a cycle of completion
	a_zs_mode_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		(state == ST_ZS && step_done && !mode_wr && mode == cal_seq_pkg::MODE_ZS_SELF)
		|=> mode == cal_seq_pkg::MODE_NORMAL)
		else $error("zero-scale cal did not return mode to normal");
	a_fs_mode_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		(state == ST_FS && step_done && !mode_wr)
		|=> mode == cal_seq_pkg::MODE_NORMAL)
		else $error("full-scale cal did not return mode to normal");
	a_zs_start: assert property (@(posedge mclk) disable iff (!rst_n)
		(state == ST_IDLE && !mode_wr && mode == cal_seq_pkg::MODE_ZS_SELF)
		|=> step_start && step_kind == cal_seq_pkg::STEP_ZS)
		else $error("zero-scale step not issued");
	a_fs_start: assert property (@(posedge mclk) disable iff (!rst_n)
		(state == ST_IDLE && !mode_wr && mode == cal_seq_pkg::MODE_FS_SELF)
		|=> step_start && step_kind == cal_seq_pkg::STEP_FS)
		else $error("full-scale step not issued");
	a_bg_no_fs: assert property (@(posedge mclk) disable iff (!rst_n)
		(step_start && mode == cal_seq_pkg::MODE_BG_CAL) |-> step_kind != cal_seq_pkg::STEP_FS)
		else $error("background mode issued full-scale step");
	a_bg_chan: assert property (@(posedge mclk) disable iff (!rst_n)
		step_start |-> step_chan == chan)
		else $error("step channel differs from selected channel");
	a_cal_ready_high: assert property (@(posedge mclk) disable iff (!rst_n)
		(mode_wr && wr_mode == cal_seq_pkg::MODE_ZS_SELF) |=> conv_valid_n)
		else $error("ready not high at zero-scale start");
	a_fs_ready_high: assert property (@(posedge mclk) disable iff (!rst_n)
		(mode_wr && wr_mode == cal_seq_pkg::MODE_FS_SELF) |=> conv_valid_n)
		else $error("ready not high at full-scale start");
	a_ready_low: assert property (@(posedge mclk) disable iff (!rst_n)
		($fell(conv_valid_n)) |-> $past(data_load))
		else $error("ready fell without a fresh word");
	a_coef_update: assert property (@(posedge mclk) disable iff (!rst_n)
		(state == ST_ZS && step_done && !mode_wr) |=> coef_load)
		else $error("coefficients not refreshed after zero-scale cal");
	// Full-scale cal also refreshes coefficients
	a_fs_coef_update: assert property (@(posedge mclk) disable iff (!rst_n)
		(state == ST_FS && step_done && !mode_wr) |=> coef_load)
		else $error("coefficients not refreshed after full-scale cal");
	// Finished conversion hands over a data word
	a_conv_word: assert property (@(posedge mclk) disable iff (!rst_n)
		(state == ST_CONV && step_done && !mode_wr) |=> data_load && !coef_load)
		else $error("conversion finished without a data word");
	// Fresh word pulls ready low unless a one-step cal starts
	a_word_ready_low: assert property (@(posedge mclk) disable iff (!rst_n)
		(data_load && !(mode_wr && (wr_mode == cal_seq_pkg::MODE_ZS_SELF
			|| wr_mode == cal_seq_pkg::MODE_FS_SELF))) |=> !conv_valid_n)
		else $error("ready stayed high after a fresh word");
	// A write in mid-step aborts it: no load pulse follows
	a_abort_no_load: assert property (@(posedge mclk) disable iff (!rst_n)
		(mode_wr && busy) |=> !coef_load && !data_load)
		else $error("aborted step still produced a load pulse");
	// Background cal slot issues a zero-scale step
	a_bg_cal_slot: assert property (@(posedge mclk) disable iff (!rst_n)
		(state == ST_IDLE && !mode_wr && mode == cal_seq_pkg::MODE_BG_CAL && cal_slot)
		|=> step_start && step_kind == cal_seq_pkg::STEP_ZS)
		else $error("background cal slot did not issue zero-scale step");
	// Other background slots keep converting
	a_bg_conv_slot: assert property (@(posedge mclk) disable iff (!rst_n)
		(state == ST_IDLE && !mode_wr && mode == cal_seq_pkg::MODE_BG_CAL && !cal_slot)
		|=> step_start && step_kind == cal_seq_pkg::STEP_CONV)
		else $error("background conversion slot did not convert");
	// Background zero-scale completion leaves the mode field alone
	a_bg_mode_kept: assert property (@(posedge mclk) disable iff (!rst_n)
		(state == ST_ZS && step_done && !mode_wr && mode == cal_seq_pkg::MODE_BG_CAL)
		|=> mode == cal_seq_pkg::MODE_BG_CAL)
		else $error("background cal changed the mode field");
	// Each step carries the gain in force when it was issued
	a_step_gain: assert property (@(posedge mclk) disable iff (!rst_n)
		step_start |-> step_gain == $past(gain_sel))
		else $error("step gain differs from selected gain");
	// Normal and unlisted modes only run conversions
	a_plain_conv: assert property (@(posedge mclk) disable iff (!rst_n)
		(step_start && mode != cal_seq_pkg::MODE_BG_CAL && mode != cal_seq_pkg::MODE_ZS_SELF
			&& mode != cal_seq_pkg::MODE_FS_SELF) |-> step_kind == cal_seq_pkg::STEP_CONV)
		else $error("conversion mode issued a calibration step");
endmodule // adc_calibration_mode_sequencer
`default_nettype wire

/* File: hw/cal_seq_pkg.sv */
// Package: constants for the calibration mode sequencer
package cal_seq_pkg;
	// Mode field codes
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_BG_CAL = 3'h5;
	localparam logic [2:0] MODE_ZS_SELF = 3'h6;
	localparam logic [2:0] MODE_FS_SELF = 3'h7;
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic [2:0] CHAN_RESET = 3'h0;
	// Background mode: one zero-scale cal per this many background slots, the cal slot included
	localparam int BG_SLOTS = 6;
	// Analog step request codes
	localparam logic [1:0] STEP_CONV = 2'h0;
	localparam logic [1:0] STEP_ZS = 2'h1;
	localparam logic [1:0] STEP_FS = 2'h2;
endpackage

/* File: hw/cal_slot_counter.sv */
// Slot counter: picks conversion or zero-scale slot in background mode
`timescale 1ns/10ps
`default_nettype none
module cal_slot_counter #(
	parameter int SLOTS = 6
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic advance,
	output logic cal_slot
);
	localparam int W = $clog2(SLOTS);
	logic [W-1:0] slot;
	// Fewer than two slots leaves no room for conversions
	if (SLOTS < 2) begin : g_bad_slots
		$error("SLOTS must be at least 2");
	end
	// Count slots; last slot of each group is a calibration slot
	always_ff @(posedge mclk) begin
		if (!rst_n || clear) begin
			slot <= '0;
		end else if (advance) begin
			slot <= (slot == W'(SLOTS - 1)) ? '0 : slot + 1'b1;
		end
	end
	assign cal_slot = (slot == W'(SLOTS - 1));
endmodule // cal_slot_counter
`default_nettype wire

/* File: tb/adc_calibration_mode_sequencer_tb.sv */
// Testbench: mode writes against a core model, queued expectations
`timescale 1ns/10ps
`default_nettype none
module adc_calibration_mode_sequencer_tb;
	typedef struct {logic [2:0] k, c, g, m; logic cf;} note_t;
	logic mclk = 1'b0, rst_n = 1'b0, mode_wr = 1'b0, dl = 1'b0;
	logic step_done, step_start, coef_load, data_load, conv_valid_n;
	logic [2:0] opm = 3'h0, chs = 3'h0, gain = 3'h0, step_chan, step_gain, mode;
	logic [1:0] step_kind;
	logic [4:0] lat = 5'h3;
	int num_errors = 0, checks = 0, seed = 32'hC3DC, cyc = 0;
	note_t sq[$], lq[$], n;
	adc_calibration_mode_sequencer #(.BG_SLOTS(2)) adc_calibration_mode_sequencer_inst (
		.mclk(mclk), .rst_n(rst_n), .mode_wr(mode_wr), .op_mode_bit2(opm[2]),
		.op_mode_bit1(opm[1]), .op_mode_bit0(opm[0]), .chan_sel_bit2(chs[2]),
		.chan_sel_bit1(chs[1]), .chan_sel_bit0(chs[0]), .gain_sel(gain),
		.step_done(step_done), .step_start(step_start), .step_kind(step_kind),
		.step_chan(step_chan), .step_gain(step_gain), .coef_load(coef_load),
		.data_load(data_load), .mode(mode), .conv_valid_n(conv_valid_n));
	core_model core_model_inst (.mclk(mclk), .abort(mode_wr), .step_start(step_start), .lat(lat),
		.step_done(step_done));
	initial forever #12.5 mclk = ~mclk;
	task chk(input logic [2:0] got, input logic [2:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask
	task close_out;
		if (num_errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task put(input logic [2:0] k, input logic [2:0] m, input logic cf);
		sq.push_back('{k, chs, gain, m, cf});
		lq.push_back('{k, chs, gain, m, cf});
	endtask
	// Mode write with random channel and gain, then expected steps
	task wr(input logic [2:0] m, input bit track, input logic [4:0] l);
		@(posedge mclk);
		opm <= m;
		chs <= 3'($random(seed));
		gain <= 3'($random(seed));
		lat <= l;
		mode_wr <= 1'b1;
		@(posedge mclk);
		mode_wr <= 1'b0;
		@(posedge mclk);
		#1;
		if (track) begin
			case (m)
				3'h6, 3'h7: begin
					put(m - 3'h5, 3'h0, 1'b1);
					put(3'h0, 3'h0, 1'b0);
				end
				3'h5: for (int i = 0; i < 4; i++) put(3'(i % 2), 3'h5, 1'(i % 2));
				default: repeat (2) put(3'h0, m, 1'b0);
			endcase
		end
		while (sq.size() > 0 || lq.size() > 0) @(posedge mclk);
	endtask
	// Result watcher: oldest note against each issue and each load
	always @(posedge mclk) begin
		dl <= 1'b0;
		if (dl) chk({2'b0, conv_valid_n}, 3'h0);
		if (rst_n && step_start && sq.size() > 0) begin
			n = sq.pop_front();
			chk({1'b0, step_kind}, n.k);
			chk(step_chan, n.c);
			chk(step_gain, n.g);
			if (n.k != 3'h0 && n.m == 3'h0) chk({2'b0, conv_valid_n}, 3'h1);
		end
		if (rst_n && (coef_load || data_load) && lq.size() > 0) begin
			n = lq.pop_front();
			dl <= data_load;
			chk({2'b0, coef_load}, {2'b0, n.cf});
			chk(mode, n.m);
		end
	end
	// Hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			close_out();
		end
	end
	initial begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		wr(3'h7, 1'b1, 5'h4);
		wr(3'h5, 1'b1, 5'h1);
		wr(3'h6, 1'b1, 5'h9);
		for (int m = 0; m < 5; m++) wr(3'(m), 1'b1, 5'h2);
		// Abort a zero-scale step with a full-scale write
		wr(3'h6, 1'b0, 5'h1F);
		while (!step_start) @(posedge mclk);
		wr(3'h7, 1'b1, 5'h3);
		repeat (6) wr(3'h5 + 3'({$random(seed)} % 3), 1'b1, 5'({$random(seed)} % 12 + 1));
		close_out();
	end
endmodule // adc_calibration_mode_sequencer_tb
`default_nettype wire

/* File: tb/core_model.sv */
// Converter core stand-in: finishes each issued step after a set delay
`timescale 1ns/10ps
`default_nettype none
module core_model (
	input wire logic mclk,
	input wire logic abort,
	input wire logic step_start,
	input wire logic [4:0] lat,
	output logic step_done
);
	logic [4:0] cnt = 5'h0;
	initial step_done = 1'b0;
	// Host write stops the core, so a stale step never completes a new one
	always @(posedge mclk) begin
		if (abort) begin
			step_done <= 1'b0;
			cnt <= 5'h0;
		end else begin
			step_done <= (cnt == 5'h1);
			cnt <= step_start ? lat : (cnt != 5'h0 ? cnt - 5'h1 : 5'h0);
		end
	end
endmodule // core_model
`default_nettype wire
